// File: inc/fiw_pkg.sv
package fiw_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int ADDR_W = 15;
	localparam int WORD_W = 16;
	localparam int PAGE_WORDS = 64;
	localparam int OFS_W = 6;
	localparam logic [5:0] PAGE_LAST = 6'h3F;

	// ----------------------------------------
	// register offsets in data memory sector 1
	// ----------------------------------------
	localparam logic [7:0] OFS_FLASH_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CHIP_RESET_PATTERN = 8'h01;
	localparam logic [7:0] OFS_BUFFER_CLEAR_CONTROL = 8'h02;
	localparam logic [7:0] OFS_FLASH_ADDRESS_LOW = 8'h03;
	localparam logic [7:0] OFS_FLASH_ADDRESS_HIGH = 8'h04;
	localparam logic [7:0] OFS_LOAD_WORD_LOW = 8'h05;
	localparam logic [7:0] OFS_LOAD_WORD_HIGH = 8'h06;
	localparam logic [7:0] OFS_SECOND_WORD_LOW = 8'h07;
	localparam logic [7:0] OFS_SECOND_WORD_HIGH = 8'h08;
	localparam logic [7:0] OFS_THIRD_WORD_LOW = 8'h09;
	localparam logic [7:0] OFS_THIRD_WORD_HIGH = 8'h0A;
	localparam logic [7:0] OFS_FOURTH_WORD_LOW = 8'h0B;
	localparam logic [7:0] OFS_FOURTH_WORD_HIGH = 8'h0C;

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
	localparam logic [2:0] MODE_WRITE = 3'h0;
	localparam logic [2:0] MODE_PAGE_ERASE = 3'h1;
	localparam logic [2:0] MODE_READ = 3'h3;
	localparam logic [2:0] MODE_UNLOCK = 3'h6;

	// unlock key, per data pair 1..3, low and high bytes
	localparam logic [7:0] KEY_SECOND_LOW = 8'h00;
	localparam logic [7:0] KEY_THIRD_LOW = 8'h0D;
	localparam logic [7:0] KEY_FOURTH_LOW = 8'hC3;
	localparam logic [7:0] KEY_SECOND_HIGH = 8'h04;
	localparam logic [7:0] KEY_THIRD_HIGH = 8'h09;
	localparam logic [7:0] KEY_FOURTH_HIGH = 8'h40;

	// length of the unlock key window, in clock cycles
	localparam logic [11:0] UNLOCK_WIN_CYC = 12'h200;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic erase_write_enabled;
		logic [2:0] operation_select;
		logic unlock_trigger;
		logic write_initiate;
		logic read_enable;
		logic read_initiate;
	} fiw_fc0_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fiw_bus_req_t;

	typedef struct packed {
		logic erase_write_enabled;
		logic [2:0] operation_select;
		logic write_initiate;
		logic read_enable;
		logic read_initiate;
		logic [14:0] addr;
	} fiw_flash_ctl_t;

endpackage

// File: verilog/fiw_addr_ctr.sv
`timescale 1ns/1ps

module fiw_addr_ctr (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_wr_low,
	input wire logic i_wr_high,
	input wire logic [7:0] i_wdata,
	input wire logic i_inc,
	output logic [14:0] o_addr
);

	logic [14:0] addr_r;
	logic [14:0] addr_nxt;
	logic at_page_end;

	// ----------------------------------------
	// next address
	// ----------------------------------------
	assign at_page_end = (addr_r[5:0] == fiw_pkg::PAGE_LAST);

	always_comb begin
		addr_nxt = addr_r;
		if (i_wr_low) begin
			addr_nxt[7:0] = i_wdata;
		end else if (i_wr_high) begin
			addr_nxt[14:8] = i_wdata[6:0];
		end else if (i_inc && !at_page_end) begin
			// offset below the last word never carries out of the page
			addr_nxt = 15'(addr_r + 15'h0001);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_r <= 15'h0000;
		end else begin
			addr_r <= addr_nxt;
		end
	end

	assign o_addr = addr_r;

endmodule // fiw_addr_ctr

// File: verilog/fiw_write_buffer.sv
`timescale 1ns/1ps

module fiw_write_buffer (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clear_start,
	input wire logic i_load,
	input wire logic [5:0] i_load_idx,
	input wire logic [15:0] i_load_word,
	input wire logic [5:0] i_rd_idx,
	output logic [15:0] o_rd_word,
	output logic o_clearing,
	output logic o_clear_done
);

	logic [15:0] word_r [fiw_pkg::PAGE_WORDS];
	logic [5:0] clr_idx_r;
	logic clearing_r;
	logic done_r;
	logic [15:0] rd_word_r;
	logic clr_last;

	assign clr_last = clearing_r && (clr_idx_r == fiw_pkg::PAGE_LAST);

	// ----------------------------------------
	// clear walk: one word per cycle
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clearing_r <= 1'b0;
			clr_idx_r <= 6'h00;
			done_r <= 1'b0;
		end else if (i_clear_start) begin
			clearing_r <= 1'b1;
			clr_idx_r <= 6'h00;
			done_r <= 1'b0;
		end else begin
			clearing_r <= clearing_r && !clr_last;
			clr_idx_r <= clearing_r ? 6'(clr_idx_r + 6'h01) : 6'h00;
			done_r <= clr_last;
		end
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	for (genvar g = 0; g < fiw_pkg::PAGE_WORDS; g++) begin : g_word
		wire logic clr_hit = clearing_r && (clr_idx_r == 6'(g));
		wire logic ld_hit = i_load && (i_load_idx == 6'(g));
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				word_r[g] <= 16'h0000;
			end else if (clr_hit) begin
				word_r[g] <= 16'h0000;
			end else if (ld_hit) begin
				word_r[g] <= i_load_word;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_word_r <= 16'h0000;
		end else begin
			rd_word_r <= word_r[i_rd_idx];
		end
	end

	assign o_rd_word = rd_word_r;
	assign o_clearing = clearing_r;
	assign o_clear_done = done_r;

endmodule // fiw_write_buffer

// File: verilog/fiw_iap_top.sv
`timescale 1ns/1ps

// Function
// - buffer loads only once erase/write unlocked
// - clear trigger clears buffer, then self-clears
// - buffer holds 64 words of selected page
// - high byte write loads combined word
// - each load below page's last word increments address, written back
// - address saturates at page's last word
// - finished flash write clears buffer
// - low byte write only updates register
// - fifteen bit address over two registers
// - address high bit seven reads zero
// - address, four data pairs, three controls
// - registers at sector one data offsets
// - operation codes write, erase, read, unlock
// - write initiate cleared when write completes
// - enabled bit set only by hardware

module fiw_iap_top (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire fiw_pkg::fiw_bus_req_t i_bus,
	output logic [7:0] o_rdata,
	input wire logic i_write_done,
	input wire logic i_read_done,
	input wire logic [5:0] i_buf_idx,
	output logic [15:0] o_buf_word,
	output fiw_pkg::fiw_flash_ctl_t o_flash,
	output logic o_chip_reset
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic hit(input fiw_pkg::fiw_bus_req_t b,
		input logic [7:0] ofs);
		hit = b.wr && (b.addr == ofs);
	endfunction

	wire logic wr_fc0 = hit(i_bus, fiw_pkg::OFS_FLASH_CONTROL);
	wire logic wr_fc1 = hit(i_bus, fiw_pkg::OFS_CHIP_RESET_PATTERN);
	wire logic wr_fc2 = hit(i_bus, fiw_pkg::OFS_BUFFER_CLEAR_CONTROL);
	wire logic wr_flash_address_low = hit(i_bus, fiw_pkg::OFS_FLASH_ADDRESS_LOW);
	wire logic wr_flash_address_high = hit(i_bus, fiw_pkg::OFS_FLASH_ADDRESS_HIGH);
	wire logic wr_d0l = hit(i_bus, fiw_pkg::OFS_LOAD_WORD_LOW);
	wire logic wr_d0h = hit(i_bus, fiw_pkg::OFS_LOAD_WORD_HIGH);
	wire logic wr_d1l = hit(i_bus, fiw_pkg::OFS_SECOND_WORD_LOW);
	wire logic wr_d1h = hit(i_bus, fiw_pkg::OFS_SECOND_WORD_HIGH);
	wire logic wr_d2l = hit(i_bus, fiw_pkg::OFS_THIRD_WORD_LOW);
	wire logic wr_d2h = hit(i_bus, fiw_pkg::OFS_THIRD_WORD_HIGH);
	wire logic wr_d3l = hit(i_bus, fiw_pkg::OFS_FOURTH_WORD_LOW);
	wire logic wr_d3h = hit(i_bus, fiw_pkg::OFS_FOURTH_WORD_HIGH);

	// ----------------------------------------
	// state
	// ----------------------------------------
	fiw_pkg::fiw_fc0_t fc0_r;
	fiw_pkg::fiw_fc0_t fc0_nxt;
	fiw_pkg::fiw_fc0_t fc0_wr;
	logic [7:0] fc1_r;
	logic clr_bit_r;
	logic [7:0] d0l_r, d0h_r, d1l_r, d1h_r, d2l_r, d2h_r, d3l_r, d3h_r;
	logic [11:0] win_cnt_r;
	logic [7:0] rdata_r;
	logic chip_reset_r;
	logic [14:0] flash_addr;
	logic buf_clearing;
	logic buf_clear_done;

	// ----------------------------------------
	// load path
	// ----------------------------------------
	// a load is dropped while locked or while the clear walk runs, so a
	// word loaded mid-clear can never be half erased behind software
	wire logic load_ok = fc0_r.erase_write_enabled && !buf_clearing;
	wire logic buf_load = wr_d0h && load_ok;
	wire logic [15:0] load_word = {i_bus.wdata, d0l_r};

	// ----------------------------------------
	// clear triggers
	// ----------------------------------------
	wire logic clr_sw_set = wr_fc2 && i_bus.wdata[0];
	wire logic clr_start = clr_sw_set || i_write_done;

	// ----------------------------------------
	// unlock key check
	// ----------------------------------------
	wire logic key_ok = (d1l_r == fiw_pkg::KEY_SECOND_LOW) &&
		(d2l_r == fiw_pkg::KEY_THIRD_LOW) &&
		(d3l_r == fiw_pkg::KEY_FOURTH_LOW) &&
		(d1h_r == fiw_pkg::KEY_SECOND_HIGH) &&
		(d2h_r == fiw_pkg::KEY_THIRD_HIGH) &&
		(d3h_r == fiw_pkg::KEY_FOURTH_HIGH);
	wire logic win_start = wr_fc0 && fc0_wr.unlock_trigger;
	wire logic win_end = fc0_r.unlock_trigger && !win_start &&
		(win_cnt_r == 12'h001);
	wire logic unlock_grant = win_end && key_ok &&
		(fc0_r.operation_select == fiw_pkg::MODE_UNLOCK);

	// ----------------------------------------
	// flash control next value
	// ----------------------------------------
	assign fc0_wr = fiw_pkg::fiw_fc0_t'(i_bus.wdata);

	always_comb begin
		fc0_nxt = fc0_r;
		if (wr_fc0) begin
			fc0_nxt.operation_select = fc0_wr.operation_select;
			fc0_nxt.unlock_trigger = fc0_wr.unlock_trigger;
			fc0_nxt.write_initiate = fc0_wr.write_initiate;
			fc0_nxt.read_enable = fc0_wr.read_enable;
			fc0_nxt.read_initiate = fc0_wr.read_initiate;
			// software may only drop the enable, never raise it
			if (!fc0_wr.erase_write_enabled) begin
				fc0_nxt.erase_write_enabled = 1'b0;
			end
		end
		if (win_end) begin
			fc0_nxt.unlock_trigger = 1'b0;
		end
		// hardware completion loses to a set in the same cycle
		if (i_write_done && !(wr_fc0 && fc0_wr.write_initiate)) begin
			fc0_nxt.write_initiate = 1'b0;
		end
		if (i_read_done && !(wr_fc0 && fc0_wr.read_initiate)) begin
			fc0_nxt.read_initiate = 1'b0;
		end
		if (unlock_grant) begin
			fc0_nxt.erase_write_enabled = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fc0_r <= fiw_pkg::fiw_fc0_t'(fiw_pkg::RESET_BYTE);
		end else begin
			fc0_r <= fc0_nxt;
		end
	end

	// ----------------------------------------
	// unlock window timer
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			win_cnt_r <= 12'h000;
		end else if (win_start) begin
			win_cnt_r <= fiw_pkg::UNLOCK_WIN_CYC;
		end else if (win_cnt_r != 12'h000) begin
			win_cnt_r <= 12'(win_cnt_r - 12'h001);
		end
	end

	// ----------------------------------------
	// chip reset pattern
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fc1_r <= fiw_pkg::RESET_BYTE;
			chip_reset_r <= 1'b0;
		end else begin
			if (wr_fc1) begin
				fc1_r <= i_bus.wdata;
			end
			chip_reset_r <= wr_fc1 &&
				(i_bus.wdata == fiw_pkg::CHIP_RESET_KEY);
		end
	end

	// ----------------------------------------
	// buffer clear control bit
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clr_bit_r <= 1'b0;
		end else if (clr_sw_set) begin
			clr_bit_r <= 1'b1;
		end else if (buf_clear_done) begin
			clr_bit_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// data register pairs
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			d0l_r <= fiw_pkg::RESET_BYTE;
			d0h_r <= fiw_pkg::RESET_BYTE;
		end else begin
			if (wr_d0l) begin
				d0l_r <= i_bus.wdata;
			end
			if (wr_d0h) begin
				d0h_r <= i_bus.wdata;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			d1l_r <= fiw_pkg::RESET_BYTE;
			d1h_r <= fiw_pkg::RESET_BYTE;
			d2l_r <= fiw_pkg::RESET_BYTE;
			d2h_r <= fiw_pkg::RESET_BYTE;
		end else begin
			if (wr_d1l) d1l_r <= i_bus.wdata;
			if (wr_d1h) d1h_r <= i_bus.wdata;
			if (wr_d2l) d2l_r <= i_bus.wdata;
			if (wr_d2h) d2h_r <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			d3l_r <= fiw_pkg::RESET_BYTE;
			d3h_r <= fiw_pkg::RESET_BYTE;
		end else begin
			if (wr_d3l) d3l_r <= i_bus.wdata;
			if (wr_d3h) d3h_r <= i_bus.wdata;
		end
	end

	// ----------------------------------------
	// address and buffer
	// ----------------------------------------
	fiw_addr_ctr u_addr (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_wr_low(wr_flash_address_low),
		.i_wr_high(wr_flash_address_high),
		.i_wdata(i_bus.wdata),
		.i_inc(buf_load),
		.o_addr(flash_addr)
	);

	fiw_write_buffer u_buf (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_clear_start(clr_start),
		.i_load(buf_load),
		.i_load_idx(flash_addr[5:0]),
		.i_load_word(load_word),
		.i_rd_idx(i_buf_idx),
		.o_rd_word(o_buf_word),
		.o_clearing(buf_clearing),
		.o_clear_done(buf_clear_done)
	);

	// ----------------------------------------
	// read back
	// ----------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		case (i_bus.addr)
			fiw_pkg::OFS_FLASH_CONTROL: rd_mux = 8'(fc0_r);
			fiw_pkg::OFS_CHIP_RESET_PATTERN: rd_mux = fc1_r;
			fiw_pkg::OFS_BUFFER_CLEAR_CONTROL: rd_mux = {7'h00, clr_bit_r};
			fiw_pkg::OFS_FLASH_ADDRESS_LOW: rd_mux = flash_addr[7:0];
			fiw_pkg::OFS_FLASH_ADDRESS_HIGH:
				rd_mux = {1'b0, flash_addr[14:8]};
			fiw_pkg::OFS_LOAD_WORD_LOW: rd_mux = d0l_r;
			fiw_pkg::OFS_LOAD_WORD_HIGH: rd_mux = d0h_r;
			fiw_pkg::OFS_SECOND_WORD_LOW: rd_mux = d1l_r;
			fiw_pkg::OFS_SECOND_WORD_HIGH: rd_mux = d1h_r;
			fiw_pkg::OFS_THIRD_WORD_LOW: rd_mux = d2l_r;
			fiw_pkg::OFS_THIRD_WORD_HIGH: rd_mux = d2h_r;
			fiw_pkg::OFS_FOURTH_WORD_LOW: rd_mux = d3l_r;
			fiw_pkg::OFS_FOURTH_WORD_HIGH: rd_mux = d3h_r;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r <= 8'h00;
		end else if (i_bus.rd) begin
			rdata_r <= rd_mux;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_rdata = rdata_r;
	assign o_chip_reset = chip_reset_r;
	assign o_flash.erase_write_enabled = fc0_r.erase_write_enabled;
	assign o_flash.operation_select = fc0_r.operation_select;
	assign o_flash.write_initiate = fc0_r.write_initiate;
	assign o_flash.read_enable = fc0_r.read_enable;
	assign o_flash.read_initiate = fc0_r.read_initiate;
	assign o_flash.addr = flash_addr;

endmodule // fiw_iap_top

// File: dv/fiw_iap_checker.sv
`timescale 1ns/1ps

module fiw_iap_checker (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire fiw_pkg::fiw_bus_req_t i_bus,
	input wire logic [7:0] o_rdata,
	input wire logic i_write_done,
	input wire fiw_pkg::fiw_flash_ctl_t o_flash,
	input wire logic o_chip_reset
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [6:0] clr_r;
	wire wr_hi = i_bus.wr && i_bus.addr == 8'h06;
	wire en = o_flash.erase_write_enabled;
	wire [7:0] lo_w = o_flash.addr[7:0];
	wire [7:0] hi_w = {1'b0, o_flash.addr[14:8]};
	wire clr_go = i_write_done || (i_bus.wr && i_bus.addr == 8'h02
		&& i_bus.wdata[0]);
	wire crst_go = i_bus.wr && i_bus.addr == 8'h01 && i_bus.wdata == 8'h55;

	// the end of a clear walk is not seen at the ports, so loads near one
	// are left out of the increment check
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			clr_r <= 7'h00;
		else if (clr_go)
			clr_r <= 7'h44;
		else if (clr_r != 7'h00)
			clr_r <= clr_r - 7'h01;
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_locked;
		wr_hi && !en |=> $stable(o_flash.addr);
	endproperty
	a_locked: assert property (p_locked) else $error("locked load moved address");
	property p_inc;
		wr_hi && en && clr_r == 7'h00 && o_flash.addr[5:0] != 6'h3F
		|=> o_flash.addr == $past(o_flash.addr) + 15'h0001;
	endproperty
	a_inc: assert property (p_inc) else $error("load did not add one");
	property p_sat;
		wr_hi && o_flash.addr[5:0] == 6'h3F |=> $stable(o_flash.addr);
	endproperty
	a_sat: assert property (p_sat) else $error("address left page end");
	property p_low;
		i_bus.wr && i_bus.addr == 8'h05 |=> $stable(o_flash.addr);
	endproperty
	a_low: assert property (p_low) else $error("low byte moved address");
	property p_wdone;
		i_write_done && !(i_bus.wr && i_bus.addr == 8'h00)
		|=> !o_flash.write_initiate;
	endproperty
	a_wdone: assert property (p_wdone) else $error("write bit kept");
	property p_rd_lo;
		i_bus.rd && i_bus.addr == 8'h03 |=> o_rdata == $past(lo_w);
	endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("low address read");
	property p_rd_hi;
		i_bus.rd && i_bus.addr == 8'h04 |=> o_rdata == $past(hi_w);
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("high address read");
	property p_unmap;
		i_bus.rd && i_bus.addr > 8'h0C |=> o_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_crst;
		1'b1 |=> o_chip_reset == $past(crst_go);
	endproperty
	a_crst: assert property (p_crst) else $error("chip reset pulse");

	c_inc: cover property (wr_hi && en ##1 o_flash.addr[5:0] == 6'h3F);
	c_sat: cover property (wr_hi && en && o_flash.addr[5:0] == 6'h3F);
	c_wdone: cover property (i_write_done ##1 !o_flash.write_initiate);
endmodule // fiw_iap_checker

bind fiw_iap_top fiw_iap_checker i_fiw_iap_checker (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
	.i_write_done(i_write_done), .o_flash(o_flash),
	.o_chip_reset(o_chip_reset));

// File: dv/fiw_flash_seq.sv
`timescale 1ns/1ps

module fiw_flash_seq (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_slow,
	input wire logic i_wt,
	input wire logic i_rt,
	output logic o_write_done,
	output logic o_read_done
);
	logic [5:0] cnt_r;
	logic busy_r;
	logic wt_r;

	// busy holds one edge past the pulse so the still-set initiate bit
	// is not taken as a fresh request
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 6'h00;
			busy_r <= 1'b0;
			wt_r <= 1'b0;
			o_write_done <= 1'b0;
			o_read_done <= 1'b0;
		end else if (!busy_r) begin
			busy_r <= i_wt | i_rt;
			wt_r <= i_wt;
			cnt_r <= i_slow ? 6'h28 : 6'h02;
		end else begin
			cnt_r <= cnt_r - 6'h01;
			busy_r <= cnt_r != 6'h00;
			o_write_done <= cnt_r == 6'h01 && wt_r;
			o_read_done <= cnt_r == 6'h01 && !wt_r;
		end
	end
endmodule // fiw_flash_seq

// File: dv/tb.sv
`timescale 1ns/1ps

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("CHECK FAILED t=%0t act=%h exp=%h", $time, a, e); end end

module tb;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	fiw_pkg::fiw_bus_req_t bus = '0;
	fiw_pkg::fiw_flash_ctl_t fl;
	logic [7:0] rdata;
	logic wdone;
	logic rdone;
	logic [5:0] idx = 6'h00;
	logic [15:0] bword;
	logic slow = 1'b1;
	logic bchk = 1'b0;
	logic sel;
	logic [15:0] ex;
	logic [15:0] expq[$];
	logic [15:0] mdl [64];
	logic [15:0] w;
	logic [5:0] o;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed;

	always #5 i_clk = ~i_clk;

	fiw_iap_top i_fiw_iap_top (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_bus(bus), .o_rdata(rdata), .i_write_done(wdone),
		.i_read_done(rdone), .i_buf_idx(idx), .o_buf_word(bword),
		.o_flash(fl), .o_chip_reset());
	fiw_flash_seq i_fiw_flash_seq (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_slow(slow), .i_wt(fl.write_initiate), .i_rt(fl.read_initiate),
		.o_write_done(wdone), .o_read_done(rdone));

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) #1;
		bus = '{1'b1, 1'b0, a, d};
		@(posedge i_clk) #1;
		bus.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back({8'h00, e});
		@(posedge i_clk) #1;
		bus = '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_clk) #1;
		bus.rd = 1'b0;
	endtask

	task automatic bw(input logic [5:0] i, input logic [15:0] e);
		expq.push_back(e);
		@(posedge i_clk) #1;
		idx = i;
		@(posedge i_clk) #1;
		bchk = 1'b1;
		@(posedge i_clk) #1;
		bchk = 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// monitor and timeout
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (bus.rd === 1'b1 || bchk === 1'b1) begin
			sel = bchk;
			#2;
			ex = expq.pop_front();
			if (sel === 1'b1)
				`CHK(bword, ex)
			else
				`CHK({8'h00, rdata}, ex)
		end
	end

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			conclude();
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		seed = $urandom(32'hF14D1623);
		foreach (mdl[i]) mdl[i] = 16'h0000;
		repeat (5) @(posedge i_clk);
		#1;
		i_rst_n = 1'b1;
		for (int a = 0; a < 13; a++) rd(a[7:0], 8'h00);
		rd(8'h0D, 8'h00);
		wr(8'h01, 8'h55);
		rd(8'h01, 8'h55);
		wr(8'h03, 8'h05);
		wr(8'h05, 8'hA5);
		wr(8'h06, 8'h5A);
		rd(8'h03, 8'h05);
		bw(6'h05, 16'h0000);
		wr(8'h00, 8'h80);
		rd(8'h00, 8'h00);
		$display("test locked done");
		wr(8'h00, 8'h68);
		wr(8'h07, 8'h00);
		wr(8'h09, 8'h0D);
		wr(8'h0B, 8'hC3);
		wr(8'h08, 8'h04);
		wr(8'h0A, 8'h09);
		wr(8'h0C, 8'h40);
		repeat (520) @(posedge i_clk);
		rd(8'h00, 8'hE0);
		wr(8'h02, 8'h01);
		rd(8'h02, 8'h01);
		repeat (70) @(posedge i_clk);
		rd(8'h02, 8'h00);
		$display("test unlock and clear done");
		wr(8'h04, 8'hFF);
		rd(8'h04, 8'h7F);
		wr(8'h03, 8'hBC);
		for (int k = 0; k < 6; k++) begin
			w = 16'($urandom);
			o = (k < 4) ? 6'h3C + 6'(k) : 6'h3F;
			wr(8'h05, w[7:0]);
			rd(8'h03, {2'b10, o});
			wr(8'h06, w[15:8]);
			mdl[o] = w;
			rd(8'h03, {2'b10, (k < 3) ? o + 6'h01 : 6'h3F});
		end
		rd(8'h04, 8'h7F);
		for (int i = 59; i < 64; i++) bw(i[5:0], mdl[i]);
		$display("test page load done");
		wr(8'h02, 8'h01);
		repeat (70) @(posedge i_clk);
		bw(6'h3D, 16'h0000);
		wr(8'h03, 8'h00);
		w = 16'($urandom);
		wr(8'h05, w[7:0]);
		wr(8'h06, w[15:8]);
		bw(6'h00, w);
		wr(8'h00, 8'h84);
		for (int i = 0; i < 200 && fl.write_initiate !== 1'b0; i++)
			@(posedge i_clk);
		rd(8'h00, 8'h80);
		repeat (70) @(posedge i_clk);
		bw(6'h00, 16'h0000);
		slow = 1'b0;
		wr(8'h00, 8'hB3);
		for (int i = 0; i < 200 && fl.read_initiate !== 1'b0; i++)
			@(posedge i_clk);
		rd(8'h00, 8'hB2);
		$display("test write and read done");
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h00);
		wr(8'h06, 8'h11);
		rd(8'h03, 8'h01);
		$display("test disable done");
		conclude();
	end
endmodule // tb
